// [design/pixel_combiner_pkg.sv]
// Package of constants and types for the dual gain pixel combiner
package pixel_combiner_pkg;
    localparam int RAW_W = 11;             // Width of each gain sample
    localparam int OUT_W = 16;             // Width of combined output pixel
    localparam int SGL_W = 12;             // Width of single gain pixel
    localparam int COL_W = 10;             // Column index width
    localparam int ROW_W = 11;             // Row index width
    localparam int COEF_W = 16;            // Gain coefficient width, 4.12 fixed point
    localparam int FRAC_W = 12;            // Fraction bits of gain coefficient
    localparam int FIFO_W = 18;            // Pixel plus half tag plus end of row
    localparam int FIFO_D = 16;            // FIFO depth in words
    localparam int NCOL = 1024;            // Columns per half held in tables
    localparam int TBL_AW = 12;            // Table address width: stream, half, column
    // Register map, word addresses on the plain port
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_THRESH = 8'h01;
    localparam logic [7:0] ADDR_ROI_FIRST = 8'h02;
    localparam logic [7:0] ADDR_ROI_LAST = 8'h03;
    localparam logic [7:0] ADDR_HG_GAIN = 8'h04;
    localparam logic [7:0] ADDR_LG_GAIN = 8'h05;
    localparam logic [7:0] ADDR_TBL_ADDR = 8'h06;
    localparam logic [7:0] ADDR_TBL_DATA = 8'h07;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_PIX_COUNT = 8'h09;
    // Control field positions
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_BYPASS = 1;
    localparam int CTRL_BYP_LOW = 2;
    localparam int CTRL_ROI_EN = 3;
    localparam int CTRL_GLOBAL_EXP = 4;
    localparam int CTRL_W = 5;
    // Reset values
    localparam logic [RAW_W-1:0] THRESH_RST = 11'h700;
    localparam logic [COEF_W-1:0] GAIN_UNITY = 16'h1000;
    localparam logic [3:0] ADC_GAIN_RST = 4'h0;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    // Maximum codes for clamping
    localparam logic [OUT_W-1:0] OUT_MAX = 16'hffff;
    localparam logic [SGL_W-1:0] SGL_MAX = 12'hfff;
    // Pipeline states, Gray coded along idle, fetch, apply
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_APPLY = 2'b11
    } pipe_state_t;
endpackage : pixel_combiner_pkg

// [design/pixel_fifo.sv]
// Parameterised synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module pixel_fifo
#(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
)
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];   // Storage, no reset needed
    logic [AW:0] wr_q;                 // Write pointer with wrap bit
    logic [AW:0] rd_q;                 // Read pointer with wrap bit
    wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire empty = (wr_q == rd_q);
    wire push = in_valid_i && !full;
    wire pop = out_ready_i && !empty;
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem_q[rd_q[AW-1:0]];
    // Storage write
    always_ff @(posedge clk_i)
    begin
        if (push)
            mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
    // Pointer update
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
        end
    end
endmodule : pixel_fifo

// [design/pixel_combiner.sv]
// Dual gain pixel combiner: selection, compensation, region and output FIFO
// Summary of operation
// RULE1 - Both gain samples of a pixel arrive together
// RULE2 - Each gain sample is eleven bits wide
// RULE3 - Threshold picks high or low gain per pixel
// RULE4 - Offset and gain corrected with chosen stream's coefficients
// RULE5 - Gain covers pixel, node amp, relative path gain
// RULE6 - Combined mode emits sixteen bit pixels
// RULE7 - Bypass mode emits twelve bit single gain pixels
// RULE8 - Top and bottom halves accepted independently
// RULE9 - Each column has its own coefficient pair
// RULE10 - Each converter channel holds its own gain setting
// RULE11 - Three gain settings under either exposure mode
// RULE12 - Rows outside region produce no pixels
// RULE13 - Threshold and coefficient tables configurable; high below threshold
`timescale 1ns/1ps
module pixel_combiner
import pixel_combiner_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    // Register port
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [31:0] REG_RDATA_O,
    // Top half source
    input wire logic TOP_VALID_I,
    output logic TOP_READY_O,
    input wire logic [RAW_W-1:0] TOP_HIGH_I,
    input wire logic [RAW_W-1:0] TOP_LOW_I,
    input wire logic [COL_W-1:0] TOP_COL_I,
    input wire logic [ROW_W-1:0] TOP_ROW_I,
    input wire logic TOP_EOL_I,
    // Bottom half source
    input wire logic BOT_VALID_I,
    output logic BOT_READY_O,
    input wire logic [RAW_W-1:0] BOT_HIGH_I,
    input wire logic [RAW_W-1:0] BOT_LOW_I,
    input wire logic [COL_W-1:0] BOT_COL_I,
    input wire logic [ROW_W-1:0] BOT_ROW_I,
    input wire logic BOT_EOL_I,
    // Converter gain settings toward the sensor
    output logic [3:0] HIGH_ADC_GAIN_O,
    output logic [3:0] LOW_ADC_GAIN_O,
    output logic GLOBAL_EXPOSURE_MODE_O,
    // Pixel output toward the host link
    output logic PIX_VALID_O,
    input wire logic PIX_READY_I,
    output logic [OUT_W-1:0] PIX_DATA_O,
    output logic PIX_HALF_O,
    output logic PIX_EOL_O
);
    // Configuration registers
    logic [CTRL_W-1:0] ctrl_q;
    logic [RAW_W-1:0] thresh_q;
    logic [ROW_W-1:0] roi_first_q;
    logic [ROW_W-1:0] roi_last_q;
    logic [3:0] hg_gain_q;
    logic [3:0] lg_gain_q;
    logic [TBL_AW-1:0] tbl_addr_q;
    logic [31:0] rdata_q;
    logic [31:0] pix_count_q;          // Pixels pushed into the FIFO
    logic drop_q;                      // Sticky: apply stage stalled on FIFO full
    // Pipeline registers
    pipe_state_t state_q;
    logic src_half_q;                  // Half that is being served
    logic use_low_q;                   // Chosen stream
    logic [RAW_W-1:0] sample_q;
    logic eol_q;
    logic last_half_q;                 // Round robin memory
    logic [TBL_AW-1:0] taddr_q; // Entry of pixel in flight
    logic fifo_valid_q;
    logic [FIFO_W-1:0] fifo_data_q;
    logic out_valid_q;
    logic [FIFO_W-1:0] out_data_q;
    // Coefficient table: offset in the high half, gain in the low half
    logic [31:0] tbl_hi_rdata;
    logic [31:0] tbl_lo_rdata;

    wire enable = ctrl_q[CTRL_ENABLE];
    wire bypass = ctrl_q[CTRL_BYPASS];
    wire byp_low = ctrl_q[CTRL_BYP_LOW];
    wire roi_en = ctrl_q[CTRL_ROI_EN];

    // Region test, used for both halves
    function automatic logic in_region(input logic [ROW_W-1:0] row,
        input logic on, input logic [ROW_W-1:0] first, input logic [ROW_W-1:0] last);
        in_region = !on || (row >= first && row <= last);
    endfunction : in_region

    // Stream choice: high gain while it stays below threshold, else low
    function automatic logic pick_low(input logic [RAW_W-1:0] high,
        input logic [RAW_W-1:0] thr, input logic byp, input logic bl);
        pick_low = byp ? bl : (high >= thr);
    endfunction : pick_low

    // Source arbitration; both halves share one pipeline, alternating
    wire fifo_in_ready;
    wire pipe_free = (state_q == ST_IDLE) && enable;
    wire pick_bot = BOT_VALID_I && (!TOP_VALID_I || !last_half_q);
    wire take_top = pipe_free && TOP_VALID_I && !pick_bot; // RULE8
    wire take_bot = pipe_free && pick_bot; // RULE8
    wire take = take_top || take_bot;
    wire [RAW_W-1:0] s_high = take_bot ? BOT_HIGH_I : TOP_HIGH_I; // RULE1
    wire [RAW_W-1:0] s_low = take_bot ? BOT_LOW_I : TOP_LOW_I; // RULE2
    wire [COL_W-1:0] s_col = take_bot ? BOT_COL_I : TOP_COL_I;
    wire [ROW_W-1:0] s_row = take_bot ? BOT_ROW_I : TOP_ROW_I;
    wire s_eol = take_bot ? BOT_EOL_I : TOP_EOL_I;
    wire s_in_roi = in_region(s_row, roi_en, roi_first_q, roi_last_q); // RULE12
    wire s_low_pick = pick_low(s_high, thresh_q, bypass, byp_low); // RULE3 RULE13
    assign TOP_READY_O = take_top;
    assign BOT_READY_O = take_bot;
    // Table address: stream, half, column, one entry per column and path
    wire [TBL_AW-1:0] pipe_taddr = {s_low_pick, take_bot, s_col}; // RULE9
    wire cpu_tbl_wr = REG_WR_I && (REG_ADDR_I == ADDR_TBL_DATA);
    wire [TBL_AW-1:0] tbl_raddr = take ? pipe_taddr : (state_q == ST_IDLE) ? tbl_addr_q : taddr_q;

    // Correction arithmetic: (sample - offset) * gain, gain in 4.12 form
    wire [15:0] offset = tbl_hi_rdata[31:16];
    wire [15:0] gain = tbl_lo_rdata[15:0];
    wire [16:0] diff = {6'h00, sample_q} - {1'b0, offset};
    wire [15:0] pos = diff[16] ? 16'h0000 : diff[15:0];
    wire [31:0] prod = pos * gain; // RULE4 RULE5
    wire [19:0] scaled = prod[31:FRAC_W];
    wire [OUT_W-1:0] comb = (|scaled[19:OUT_W]) ? OUT_MAX : scaled[OUT_W-1:0]; // RULE6
    wire [SGL_W-1:0] sgl = (|scaled[19:SGL_W]) ? SGL_MAX : scaled[SGL_W-1:0]; // RULE7
    wire [OUT_W-1:0] result = bypass ? {4'h0, sgl} : comb;

    // Register decode
    wire hit_ctrl = (REG_ADDR_I == ADDR_CTRL);
    wire [31:0] rd_mux =
        (REG_ADDR_I == ADDR_CTRL) ? {27'h0, ctrl_q} :
        (REG_ADDR_I == ADDR_THRESH) ? {21'h0, thresh_q} :
        (REG_ADDR_I == ADDR_ROI_FIRST) ? {21'h0, roi_first_q} :
        (REG_ADDR_I == ADDR_ROI_LAST) ? {21'h0, roi_last_q} :
        (REG_ADDR_I == ADDR_HG_GAIN) ? {28'h0, hg_gain_q} :
        (REG_ADDR_I == ADDR_LG_GAIN) ? {28'h0, lg_gain_q} :
        (REG_ADDR_I == ADDR_TBL_ADDR) ? {20'h0, tbl_addr_q} :
        (REG_ADDR_I == ADDR_TBL_DATA) ? {tbl_hi_rdata[31:16], tbl_lo_rdata[15:0]} :
        (REG_ADDR_I == ADDR_STATUS) ? {29'h0, drop_q, state_q != ST_IDLE, enable} :
        (REG_ADDR_I == ADDR_PIX_COUNT) ? pix_count_q : UNMAPPED_DATA;

    // Coefficient memory, written by software, read by the pipeline
    pixel_fifo_table u_table (
        .clk_i(CORE_CLK_I),
        .wr_i(cpu_tbl_wr),
        .waddr_i(tbl_addr_q),
        .wdata_i(REG_WDATA_I),
        .raddr_i(tbl_raddr),
        .rdata_o(tbl_hi_rdata)
    );
    assign tbl_lo_rdata = tbl_hi_rdata;

    // Configuration writes
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            ctrl_q <= '0;
            thresh_q <= THRESH_RST;
            roi_first_q <= '0;
            roi_last_q <= '1;
            hg_gain_q <= ADC_GAIN_RST;
            lg_gain_q <= ADC_GAIN_RST;
        end
        else if (REG_WR_I)
        begin
            if (hit_ctrl)
                ctrl_q <= REG_WDATA_I[CTRL_W-1:0]; // RULE11
            else if (REG_ADDR_I == ADDR_THRESH)
                thresh_q <= REG_WDATA_I[RAW_W-1:0]; // RULE13
            else if (REG_ADDR_I == ADDR_ROI_FIRST)
                roi_first_q <= REG_WDATA_I[ROW_W-1:0];
            else if (REG_ADDR_I == ADDR_ROI_LAST)
                roi_last_q <= REG_WDATA_I[ROW_W-1:0];
            else if (REG_ADDR_I == ADDR_HG_GAIN)
                hg_gain_q <= REG_WDATA_I[3:0]; // RULE10
            else if (REG_ADDR_I == ADDR_LG_GAIN)
                lg_gain_q <= REG_WDATA_I[3:0]; // RULE10
        end
    end

    // Table pointer, steps after each data write for fast loading
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            tbl_addr_q <= '0;
        else if (REG_WR_I && REG_ADDR_I == ADDR_TBL_ADDR)
            tbl_addr_q <= REG_WDATA_I[TBL_AW-1:0];
        else if (cpu_tbl_wr)
            tbl_addr_q <= tbl_addr_q + 1'b1;
    end

    // Read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            rdata_q <= '0;
        else
            rdata_q <= REG_RD_I ? rd_mux : '0;
    end

    // Pipeline: take a pixel, fetch its coefficients, apply them
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            state_q <= ST_IDLE;
            src_half_q <= 1'b0;
            use_low_q <= 1'b0;
            sample_q <= '0;
            eol_q <= 1'b0;
            last_half_q <= 1'b0;
            taddr_q <= '0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    // Rows outside the region are swallowed here
                    if (take && s_in_roi) // RULE12
                    begin
                        state_q <= ST_FETCH;
                        src_half_q <= take_bot;
                        use_low_q <= s_low_pick;
                        sample_q <= s_low_pick ? s_low : s_high; // RULE3
                        eol_q <= s_eol;
                        taddr_q <= pipe_taddr;
                    end
                    if (take)
                        last_half_q <= take_bot;
                end
                ST_FETCH:
                    state_q <= ST_APPLY;
                ST_APPLY:
                    // Hold until the FIFO stage is free
                    if (!fifo_valid_q || fifo_in_ready)
                        state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // FIFO feed stage and statistics
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            fifo_valid_q <= 1'b0;
            fifo_data_q <= '0;
            pix_count_q <= '0;
            drop_q <= 1'b0;
        end
        else
        begin
            if (fifo_valid_q && fifo_in_ready)
                fifo_valid_q <= 1'b0;
            if (state_q == ST_APPLY && (!fifo_valid_q || fifo_in_ready))
            begin
                fifo_valid_q <= 1'b1;
                fifo_data_q <= {eol_q, src_half_q, result}; // RULE6 RULE7
                pix_count_q <= pix_count_q + 1'b1;
            end
            // Set wins over a clearing control write
            if (state_q == ST_APPLY && fifo_valid_q && !fifo_in_ready)
                drop_q <= 1'b1;
            else if (REG_WR_I && hit_ctrl)
                drop_q <= 1'b0;
        end
    end

    // Output FIFO; back-pressure stalls the pipeline in the apply state
    wire fifo_out_valid;
    wire [FIFO_W-1:0] fifo_out_data;
    wire out_take = fifo_out_valid && (!out_valid_q || PIX_READY_I);
    pixel_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
        .clk_i(CORE_CLK_I),
        .rst_b_i(RST_B_I),
        .in_valid_i(fifo_valid_q),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_data_q),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(out_take),
        .out_data_o(fifo_out_data)
    );

    // Registered output stage toward the link
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            out_valid_q <= 1'b0;
            out_data_q <= '0;
        end
        else if (out_take)
        begin
            out_valid_q <= 1'b1;
            out_data_q <= fifo_out_data;
        end
        else if (PIX_READY_I)
            out_valid_q <= 1'b0;
    end

    assign REG_RDATA_O = rdata_q;
    assign PIX_VALID_O = out_valid_q;
    assign PIX_DATA_O = out_data_q[OUT_W-1:0];
    assign PIX_HALF_O = out_data_q[OUT_W];
    assign PIX_EOL_O = out_data_q[OUT_W+1];
    assign HIGH_ADC_GAIN_O = hg_gain_q; // RULE10
    assign LOW_ADC_GAIN_O = lg_gain_q; // RULE10
    assign GLOBAL_EXPOSURE_MODE_O = ctrl_q[CTRL_GLOBAL_EXP]; // RULE11
endmodule : pixel_combiner

// Coefficient memory with registered read data
module pixel_fifo_table
import pixel_combiner_pkg::*;
(
    input wire logic clk_i,
    input wire logic wr_i,
    input wire logic [TBL_AW-1:0] waddr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [TBL_AW-1:0] raddr_i,
    output logic [31:0] rdata_o
);
    logic [31:0] mem_q [2**TBL_AW];    // Offset in upper half, gain in lower
    // Write and registered read
    always_ff @(posedge clk_i)
    begin
        if (wr_i)
            mem_q[waddr_i] <= wdata_i;
        rdata_o <= mem_q[raddr_i];
    end
endmodule : pixel_fifo_table

// [testbench/pixel_combiner_sva.sv]
// Port checker for the dual gain pixel combiner
`timescale 1ns/1ps
module pixel_combiner_sva
import pixel_combiner_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [31:0] REG_RDATA_O,
    input wire logic TOP_VALID_I,
    input wire logic TOP_READY_O,
    input wire logic BOT_VALID_I,
    input wire logic BOT_READY_O,
    input wire logic [3:0] HIGH_ADC_GAIN_O,
    input wire logic [3:0] LOW_ADC_GAIN_O,
    input wire logic GLOBAL_EXPOSURE_MODE_O,
    input wire logic PIX_VALID_O,
    input wire logic PIX_READY_I,
    input wire logic [OUT_W-1:0] PIX_DATA_O,
    input wire logic PIX_HALF_O,
    input wire logic PIX_EOL_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_B_I);
    logic [CTRL_W-1:0] ctrl_q; // Shadow of the control word
    wire ctrl_wr = REG_WR_I && REG_ADDR_I == ADDR_CTRL;
    wire [3:0] wr_gain = REG_WDATA_I[3:0]; // Gain field of a write
    wire wr_exp = REG_WDATA_I[CTRL_GLOBAL_EXP];
    // Shadow of software control writes
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
        if (!RST_B_I)
            ctrl_q <= '0;
        else if (ctrl_wr)
            ctrl_q <= REG_WDATA_I[CTRL_W-1:0];
    // Take with region off, then two cycles with no accept
    sequence s_take;
        !ctrl_q[CTRL_ROI_EN] && ((TOP_VALID_I && TOP_READY_O) || (BOT_VALID_I && BOT_READY_O));
    endsequence
    sequence s_busy;
        (!TOP_READY_O && !BOT_READY_O) [*2];
    endsequence
    a_take_spacing: assert property (s_take |=> s_busy)
        else $error("pixel accepted inside pipeline gap");
    a_one_source: assert property (!(TOP_VALID_I && TOP_READY_O && BOT_VALID_I && BOT_READY_O))
        else $error("both halves accepted at once");
    a_off_quiet: assert property (!ctrl_q[CTRL_ENABLE] |-> !TOP_READY_O && !BOT_READY_O)
        else $error("ready while disabled");
    a_rdata_idle: assert property (!REG_RD_I |=> REG_RDATA_O == 32'h0000_0000)
        else $error("read data outside read cycle");
    a_pix_hold: assert property (PIX_VALID_O && !PIX_READY_I |=> PIX_VALID_O && $stable(PIX_DATA_O)
        && $stable(PIX_HALF_O) && $stable(PIX_EOL_O))
        else $error("output pixel changed while stalled");
    a_bypass_width: assert property (ctrl_q[CTRL_BYPASS] && PIX_VALID_O |-> PIX_DATA_O[15:12] == 4'h0)
        else $error("bypass pixel wider than twelve bits");
    a_high_gain: assert property (REG_WR_I && REG_ADDR_I == ADDR_HG_GAIN
        |=> HIGH_ADC_GAIN_O == $past(wr_gain))
        else $error("high converter gain not updated");
    a_low_gain: assert property (REG_WR_I && REG_ADDR_I == ADDR_LG_GAIN
        |=> LOW_ADC_GAIN_O == $past(wr_gain))
        else $error("low converter gain not updated");
    a_exposure_bit: assert property (ctrl_wr |=> GLOBAL_EXPOSURE_MODE_O == $past(wr_exp))
        else $error("exposure mode output not updated");
endmodule : pixel_combiner_sva

bind pixel_combiner pixel_combiner_sva chk_u (.CORE_CLK_I, .RST_B_I, .REG_ADDR_I, .REG_WDATA_I,
    .REG_WR_I, .REG_RD_I, .REG_RDATA_O, .TOP_VALID_I, .TOP_READY_O, .BOT_VALID_I, .BOT_READY_O,
    .HIGH_ADC_GAIN_O, .LOW_ADC_GAIN_O, .GLOBAL_EXPOSURE_MODE_O, .PIX_VALID_O, .PIX_READY_I,
    .PIX_DATA_O, .PIX_HALF_O, .PIX_EOL_O);

// [testbench/sensor_half_model.sv]
// Behavioural model of one sensor half with its two gain converters
`timescale 1ns/1ps
module sensor_half_model
import pixel_combiner_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic go_i,
    input wire logic [RAW_W-1:0] thr_i,
    input wire logic ready_i,
    output logic valid_o,
    output logic [RAW_W-1:0] high_o,
    output logic [RAW_W-1:0] low_o,
    output logic [COL_W-1:0] col_o,
    output logic [ROW_W-1:0] row_o,
    output logic eol_o
);
    logic [1:0] col_q; // Short rows of four columns
    logic [3:0] row_q; // Rows wrap after sixteen
    assign col_o = COL_W'(col_q);
    assign row_o = ROW_W'(row_q);
    assign eol_o = valid_o && col_q == 2'h3;
    // Beat held until taken; idle samples keep changing
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            valid_o <= 1'b0;
            col_q <= 2'h0;
            row_q <= 4'h0;
            high_o <= '0;
            low_o <= '0;
        end
        else if (!valid_o || ready_i)
        begin
            if (valid_o)
            begin
                col_q <= col_q + 2'h1;
                row_q <= row_q + 4'(col_q == 2'h3);
            end
            valid_o <= go_i && $urandom_range(3) != 0;
            // Both samples in one beat, the high one often at or one below the threshold
            high_o <= ($urandom_range(3) == 0) ? thr_i - RAW_W'($urandom_range(1))
                : RAW_W'($urandom_range(2047, 64));
            low_o <= RAW_W'($urandom_range(2047, 64));
        end
    end
endmodule : sensor_half_model

// [testbench/dual_gain_pixel_combiner_tb.sv]
// Self-checking bench for the dual gain pixel combiner
`timescale 1ns/1ps
module dual_gain_pixel_combiner_tb
import pixel_combiner_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic go = 1'b0;
    logic pix_rdy = 1'b0;
    logic [RAW_W-1:0] thr_v = THRESH_RST; // Threshold now programmed
    logic byp = 1'b0; // Mode as last written
    logic bl = 1'b0;
    logic region_of_interest = 1'b0;
    int failures = 0;
    int num_checks = 0;
    wire [31:0] rdata;
    wire v [2];
    wire rdy [2];
    wire [RAW_W-1:0] hi [2];
    wire [RAW_W-1:0] lo [2];
    wire [COL_W-1:0] col [2];
    wire [ROW_W-1:0] row [2];
    wire eol [2];
    wire [3:0] hg_o;
    wire [3:0] lg_o;
    wire gexp_o;
    wire pix_valid;
    wire [OUT_W-1:0] pix_data;
    wire pix_half;
    wire pix_eol;
    logic [16:0] exp_q [2][$]; // Expected {eol, pixel} per half
    logic [7:0] ra [7] = '{ADDR_CTRL, ADDR_THRESH, ADDR_ROI_FIRST, ADDR_ROI_LAST,
        ADDR_HG_GAIN, ADDR_LG_GAIN, 8'h3f};
    logic [31:0] rv [7] = '{32'h0, 32'h700, 32'h0, 32'h7ff, 32'h0, 32'h0, UNMAPPED_DATA};
    logic [4:0] md [4] = '{5'h01, 5'h19, 5'h03, 5'h17}; // Both exposure modes, all outputs
    always #2.5 clk = ~clk;
    pixel_combiner dut_u (.CORE_CLK_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
        .TOP_VALID_I(v[0]), .TOP_READY_O(rdy[0]), .TOP_HIGH_I(hi[0]), .TOP_LOW_I(lo[0]),
        .TOP_COL_I(col[0]), .TOP_ROW_I(row[0]), .TOP_EOL_I(eol[0]),
        .BOT_VALID_I(v[1]), .BOT_READY_O(rdy[1]), .BOT_HIGH_I(hi[1]), .BOT_LOW_I(lo[1]),
        .BOT_COL_I(col[1]), .BOT_ROW_I(row[1]), .BOT_EOL_I(eol[1]),
        .HIGH_ADC_GAIN_O(hg_o), .LOW_ADC_GAIN_O(lg_o), .GLOBAL_EXPOSURE_MODE_O(gexp_o),
        .PIX_VALID_O(pix_valid), .PIX_READY_I(pix_rdy), .PIX_DATA_O(pix_data),
        .PIX_HALF_O(pix_half), .PIX_EOL_O(pix_eol));
    for (genvar h = 0; h < 2; h++)
    begin : g_half
        sensor_half_model sen_u (.clk_i(clk), .rst_b_i(rst_b), .go_i(go), .thr_i(thr_v),
            .ready_i(rdy[h]), .valid_o(v[h]), .high_o(hi[h]), .low_o(lo[h]), .col_o(col[h]),
            .row_o(row[h]), .eol_o(eol[h]));
    end
    // Coefficients differ per stream, half and column
    function automatic logic [31:0] coef(int s, int h, int c);
        return {16'(4 * c + 2 * s + h), 16'(32'h1000 + s * 32'h1000 + c * 32'h800)};
    endfunction : coef
    // Expected selection, correction and clamp
    function automatic logic [16:0] expect_pix(int h, logic [RAW_W-1:0] hs,
        logic [RAW_W-1:0] ls, int c, logic e);
        logic low;
        logic [31:0] k;
        int val;
        low = byp ? bl : !(hs < thr_v);
        k = coef(int'(low), h, c);
        val = (int'(low ? ls : hs) - int'(k[31:16])) * int'(k[15:0]) / 4096;
        if (byp && val > 4095)
            val = 4095;
        return {e, 16'(val)};
    endfunction : expect_pix
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    task automatic reg_wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(logic [7:0] a, output logic [31:0] q);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        q = rdata;
    endtask : reg_rd
    // Scoreboard: predict taken beats, compare per half
    always @(posedge clk)
    begin
        for (int h = 0; h < 2; h++)
            if (v[h] && rdy[h] && (!region_of_interest || (row[h] >= 4 && row[h] <= 9)))
                exp_q[h].push_back(expect_pix(h, hi[h], lo[h], int'(col[h]), eol[h]));
        if (pix_valid && pix_rdy)
        begin
            if (exp_q[pix_half].size() == 0)
                check("unexpected pixel", 32'h1, 32'h0);
            else
                check("pixel", {pix_eol, pix_data}, exp_q[pix_half].pop_front());
        end
    end
    initial
    begin
        #200us;
        failures++;
        end_sim();
    end
    initial
    begin
        logic [31:0] d;
        int n;
        void'($urandom(43536));
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            reg_rd(ra[i], d);
            check("reset value", d, rv[i]);
        end
        d = $urandom_range(15);
        reg_wr(ADDR_HG_GAIN, d);
        reg_wr(ADDR_LG_GAIN, d ^ 32'h5);
        #1;
        check("high adc gain", 32'(hg_o), d);
        check("low adc gain", 32'(lg_o), d ^ 32'h5);
        // Coefficients for four columns of each stream and half
        for (int s = 0; s < 2; s++)
            for (int h = 0; h < 2; h++)
            begin
                reg_wr(ADDR_TBL_ADDR, 32'({s[0], h[0], 10'h0}));
                for (int c = 0; c < 4; c++)
                    reg_wr(ADDR_TBL_DATA, coef(s, h, c));
            end
        reg_wr(ADDR_TBL_ADDR, 32'h0000_0c02);
        reg_rd(ADDR_TBL_DATA, d);
        check("table entry", d, coef(1, 1, 2));
        reg_wr(ADDR_ROI_FIRST, 32'h4);
        reg_wr(ADDR_ROI_LAST, 32'h9);
        for (int m = 0; m < 4; m++)
        begin
            thr_v = RAW_W'($urandom_range(2047, 64));
            reg_wr(ADDR_THRESH, 32'(thr_v));
            byp = md[m][CTRL_BYPASS];
            bl = md[m][CTRL_BYP_LOW];
            region_of_interest = md[m][CTRL_ROI_EN];
            reg_wr(ADDR_CTRL, 32'(md[m]));
            reg_rd(ADDR_STATUS, d);
            check("status enable", 32'(d[0]), 32'h1);
            check("exposure mode", 32'(gexp_o), 32'(md[m][CTRL_GLOBAL_EXP]));
            go <= 1'b1;
            repeat (400) @(posedge clk) pix_rdy <= $urandom_range(3) != 0;
            // Host stalls until the buffer is full
            pix_rdy <= 1'b0;
            repeat (250) @(posedge clk);
            #1;
            check("ready when full", 32'(rdy[0] | rdy[1]), 32'h0);
            @(posedge clk);
            go <= 1'b0;
            pix_rdy <= 1'b1;
            for (n = 0; n < 600 && (exp_q[0].size() + exp_q[1].size() != 0 || v[0] || v[1]); n++)
                @(posedge clk);
            if (n == 600)
            begin
                failures++;
                end_sim();
            end
            repeat (8) @(posedge clk);
            reg_wr(ADDR_CTRL, 32'h0);
        end
        end_sim();
    end
endmodule : dual_gain_pixel_combiner_tb
